// ---- common/bbc_defines.vh ----
// constants for the bus backoff, address hold and cache control pin block
`ifndef BBC_DEFINES_VH
`define BBC_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BBC_OFS_CTRL 8'h00
`define BBC_OFS_BASE 8'h04
`define BBC_OFS_STATUS 8'h08
`define BBC_OFS_RESTART 8'h0C

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BBC_CTRL_PAGING 0
`define BBC_CTRL_CD 1
`define BBC_CTRL_RESET 32'h00000000
`define BBC_BASE_PWT 3
`define BBC_BASE_PCD 4
`define BBC_BASE_RESET 32'h00000000

// ----------------------------------------
// attribute source select and bus timing
// ----------------------------------------
`define BBC_SRC_PTE 2'h0
`define BBC_SRC_PDE 2'h1
`define BBC_SRC_BASE 2'h2
`define BBC_BURST_BEATS 4
`define BBC_SYNC_STAGES 2

`endif

// ---- logic/bbc_ctrl.v ----
// bus backoff, address hold, invalidation, line fill, flush and page attribute pin logic
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
// ----------------------------------------
// Behaviour
// - backoff sampled low floats bus next clock; here the bus floats on the third clock, behind the two synchroniser stages
// - backoff never raises hold acknowledge
// - backoff beats ready in the same clock
// - stay floated while backoff is asserted
// - interrupted bus cycle restarts after backoff
// - address hold floats address bus next clock; here it floats on the third clock, behind the two synchroniser stages
// - address hold floats only the address bus
// - external strobe invalidates line at pin address
// - cache enable before first ready starts fill
// - cache enable before last ready commits line
// - flush pulse flushes whole internal cache
// - paging on drives attributes from chosen entry
// - paging off zeroes write-through, cache disable follows cd bit
// - attributes timed with cycle definition outputs
// - attribute outputs undriven during bus hold
// - cache disable bit forces cache disable pin
// ----------------------------------------
`include "bbc_defines.vh"

module bbc_ctrl #(
   parameter AW = 30,
   parameter BEATS = `BBC_BURST_BEATS
) (
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // pins from the system
   input wire bus_backoff_n_i,
   input wire address_hold_req_i,
   input wire external_address_strobe_n_i,
   input wire cacheable_enable_n_i,
   input wire flush_n_i,
   input wire ready_n_i,
   input wire burst_ready_n_i,
   input wire [AW-1:0] addr_i,
   // pins to the system
   output wire [AW-1:0] addr_o,
   output wire addr_oe_o,
   output wire addr_strobe_n_o,
   output wire write_read_o,
   output wire ctrl_oe_o,
   output wire data_oe_o,
   output wire hold_ack_o,
   output wire page_write_through_o,
   output wire page_cache_disable_o,
   output wire page_attr_oe_o,
   // core side, same clock
   input wire bus_hold_active_i,
   input wire cyc_req_i,
   input wire [AW-1:0] cyc_addr_i,
   input wire cyc_write_i,
   input wire cyc_cacheable_i,
   input wire [1:0] cyc_attr_src_i,
   input wire [1:0] pte_attr_i,
   input wire [1:0] pde_attr_i,
   output wire cyc_ack_o,
   output wire line_fill_o,
   output wire line_commit_o,
   output wire inval_req_o,
   output wire [AW-1:0] inval_addr_o,
   output wire flush_req_o
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_BUS_BACKOFF_N = 2'h3;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [6:0] pin_s1_r;
   reg [6:0] pin_s2_r;
   reg [AW-1:0] adr_s1_r;
   reg [AW-1:0] adr_s2_r;
   reg flush_prev_r;
   reg ken_prev_r;

   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_r <= 7'h7D;
         pin_s2_r <= 7'h7D;
         adr_s1_r <= {AW{1'b0}};
         adr_s2_r <= {AW{1'b0}};
         flush_prev_r <= 1'b1;
         ken_prev_r <= 1'b1;
      end else begin
         pin_s1_r <= {external_address_strobe_n_i, burst_ready_n_i, ready_n_i, flush_n_i,
                      cacheable_enable_n_i,
                      address_hold_req_i, bus_backoff_n_i};
         pin_s2_r <= pin_s1_r;
         adr_s1_r <= addr_i;
         adr_s2_r <= adr_s1_r;
         flush_prev_r <= pin_s2_r[3];
         ken_prev_r <= pin_s2_r[2];
      end
   end

   wire bus_backoff_n_s = ~pin_s2_r[0];
   wire address_hold_req_s = pin_s2_r[1];
   wire ken_s = ~ken_prev_r;
   wire flush_fall = flush_prev_r & ~pin_s2_r[3];
   wire ready_s = ~pin_s2_r[4] | ~pin_s2_r[5];
   wire ext_strobe_n_s = pin_s2_r[6];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [31:0] ctrl_r;
   reg [31:0] base_r;
   reg [15:0] restart_cnt_r;
   reg [31:0] wb_dat_r;
   reg wb_ack_r;

   wire paging_en = ctrl_r[`BBC_CTRL_PAGING];
   wire cd_bit = ctrl_r[`BBC_CTRL_CD];

   function [31:0] bbc_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] sel;
      integer i;
      begin
         bbc_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               bbc_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------
   // bus cycle state
   // ----------------------------------------
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg restart_r;
   reg [AW-1:0] addr_r;
   reg write_r;
   reg cacheable_r;
   reg fill_r;
   reg [1:0] beat_r;
   reg pwt_r;
   reg pcd_r;
   reg ads_n_r;
   reg addr_oe_r;
   reg ctrl_oe_r;
   reg data_oe_r;
   reg hold_ack_r;
   reg attr_oe_r;
   reg pwt_pin_r;
   reg pcd_pin_r;
   reg wr_pin_r;
   reg cyc_ack_r;
   reg line_fill_r;
   reg line_commit_r;
   reg inval_req_r;
   reg [AW-1:0] inval_addr_r;
   reg flush_req_r;

   // effective attributes for the request now offered
   reg [1:0] src_attr;
   always @* begin
      if (cyc_attr_src_i == `BBC_SRC_PTE) begin
         src_attr = pte_attr_i;
      end else if (cyc_attr_src_i == `BBC_SRC_PDE) begin
         src_attr = pde_attr_i;
      end else begin
         src_attr = {base_r[`BBC_BASE_PCD], base_r[`BBC_BASE_PWT]};
      end
   end
   wire eff_pwt = paging_en & src_attr[0];
   wire eff_pcd = paging_en & src_attr[1];

   wire floated = bus_backoff_n_s | bus_hold_active_i;
   wire start_ok = cyc_req_i & ~cyc_ack_r & ~floated & ~address_hold_req_s;
   wire last_beat = ~fill_r | (beat_r == BEATS[1:0] - 2'h1);
   wire first_fill = (beat_r == 2'h0) & cacheable_r & ken_s;

   always @* begin
      state_nxt = state_r;
      if (bus_backoff_n_s) begin
         state_nxt = ST_BUS_BACKOFF_N;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_ok) begin
                  state_nxt = ST_ADDR;
               end
            end
            ST_ADDR: begin
               state_nxt = ST_DATA;
            end
            ST_DATA: begin
               if (ready_s & (beat_r == 2'h0 ? ~first_fill : last_beat)) begin
                  state_nxt = ST_IDLE;
               end
            end
            default: begin
               state_nxt = restart_r ? ST_ADDR : ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         restart_r <= 1'b0;
         addr_r <= {AW{1'b0}};
         write_r <= 1'b0;
         cacheable_r <= 1'b0;
         fill_r <= 1'b0;
         beat_r <= 2'h0;
         pwt_r <= 1'b0;
         pcd_r <= 1'b0;
         restart_cnt_r <= 16'h0000;
         cyc_ack_r <= 1'b0;
         line_fill_r <= 1'b0;
         line_commit_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cyc_ack_r <= 1'b0;
         line_commit_r <= 1'b0;
         if (state_r == ST_IDLE && state_nxt == ST_ADDR) begin
            addr_r <= cyc_addr_i;
            write_r <= cyc_write_i;
            cacheable_r <= cyc_cacheable_i & ~cyc_write_i & ~eff_pcd & ~cd_bit;
            pwt_r <= eff_pwt;
            pcd_r <= eff_pcd | cd_bit;
         end
         if (bus_backoff_n_s) begin
            // a ready in the same clock is dropped and the cycle begins again
            if (state_r == ST_ADDR || state_r == ST_DATA) begin
               restart_r <= 1'b1;
               restart_cnt_r <= restart_cnt_r + 16'h0001;
            end
            fill_r <= 1'b0;
            line_fill_r <= 1'b0;
            beat_r <= 2'h0;
         end else if (state_r == ST_BUS_BACKOFF_N) begin
            restart_r <= 1'b0;
         end else if (state_r == ST_DATA && ready_s) begin
            if (beat_r == 2'h0 && first_fill) begin
               fill_r <= 1'b1;
               line_fill_r <= 1'b1;
               beat_r <= 2'h1;
            end else if (fill_r && !last_beat) begin
               beat_r <= beat_r + 2'h1;
            end else begin
               line_commit_r <= fill_r & ken_s;
               fill_r <= 1'b0;
               line_fill_r <= 1'b0;
               beat_r <= 2'h0;
               cyc_ack_r <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // pin drive and cache requests
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ads_n_r <= 1'b1;
         addr_oe_r <= 1'b0;
         ctrl_oe_r <= 1'b0;
         data_oe_r <= 1'b0;
         hold_ack_r <= 1'b0;
         attr_oe_r <= 1'b0;
         pwt_pin_r <= 1'b0;
         pcd_pin_r <= 1'b0;
         wr_pin_r <= 1'b0;
         inval_req_r <= 1'b0;
         inval_addr_r <= {AW{1'b0}};
         flush_req_r <= 1'b0;
      end else begin
         ads_n_r <= ~(state_nxt == ST_ADDR);
         addr_oe_r <= ~floated & ~address_hold_req_s;
         ctrl_oe_r <= ~floated;
         data_oe_r <= ~floated & write_r & (state_nxt == ST_DATA);
         attr_oe_r <= ~floated;
         hold_ack_r <= bus_hold_active_i;
         if (state_nxt == ST_ADDR) begin
            // definition outputs and attributes change together
            wr_pin_r <= (state_r == ST_IDLE) ? cyc_write_i : write_r;
            pwt_pin_r <= (state_r == ST_IDLE) ? eff_pwt : pwt_r;
            pcd_pin_r <= (state_r == ST_IDLE) ? (eff_pcd | cd_bit) : pcd_r;
         end
         // strobe is honoured only while our address drivers are off
         inval_req_r <= ~addr_oe_r & (address_hold_req_s | floated) & ~ext_strobe_n_s;
         if (~addr_oe_r & (address_hold_req_s | floated) & ~ext_strobe_n_s) begin
            inval_addr_r <= adr_s2_r;
         end
         flush_req_r <= flush_fall;
      end
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `BBC_CTRL_RESET;
         base_r <= `BBC_BASE_RESET;
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack_r <= wb_cyc_i & wb_stb_i & ~wb_ack_r;
         wb_dat_r <= 32'h00000000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_r) begin
            if (wb_adr_i == `BBC_OFS_CTRL) begin
               if (wb_we_i) begin
                  ctrl_r <= bbc_merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h00000003;
               end
               wb_dat_r <= ctrl_r;
            end else if (wb_adr_i == `BBC_OFS_BASE) begin
               if (wb_we_i) begin
                  base_r <= bbc_merge(base_r, wb_dat_i, wb_sel_i) & 32'h00000018;
               end
               wb_dat_r <= base_r;
            end else if (wb_adr_i == `BBC_OFS_STATUS) begin
               wb_dat_r <= {24'h000000, state_r, line_fill_r, restart_r, address_hold_req_s,
                            bus_hold_active_i, bus_backoff_n_s, ~addr_oe_r};
            end else if (wb_adr_i == `BBC_OFS_RESTART) begin
               wb_dat_r <= {16'h0000, restart_cnt_r};
            end
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_dat_o = wb_dat_r;
   assign wb_ack_o = wb_ack_r;
   assign addr_o = addr_r;
   assign addr_oe_o = addr_oe_r;
   assign addr_strobe_n_o = ads_n_r;
   assign write_read_o = wr_pin_r;
   assign ctrl_oe_o = ctrl_oe_r;
   assign data_oe_o = data_oe_r;
   assign hold_ack_o = hold_ack_r;
   assign page_write_through_o = pwt_pin_r;
   assign page_cache_disable_o = pcd_pin_r;
   assign page_attr_oe_o = attr_oe_r;
   assign cyc_ack_o = cyc_ack_r;
   assign line_fill_o = line_fill_r;
   assign line_commit_o = line_commit_r;
   assign inval_req_o = inval_req_r;
   assign inval_addr_o = inval_addr_r;
   assign flush_req_o = flush_req_r;

endmodule

// ---- verification/bbc_ctrl_props.sv ----
// assertion checker for the backoff, address hold and cache control pins
`timescale 1ns/1ns
module bbc_ctrl_props #(parameter AW = 30) (
   input wire clk_i,
   input wire rst_i,
   input wire bus_backoff_n_i,
   input wire address_hold_req_i,
   input wire external_address_strobe_n_i,
   input wire cacheable_enable_n_i,
   input wire flush_n_i,
   input wire bus_hold_active_i,
   input wire [AW-1:0] addr_i,
   input wire addr_oe_o,
   input wire ctrl_oe_o,
   input wire hold_ack_o,
   input wire page_attr_oe_o,
   input wire cyc_ack_o,
   input wire line_fill_o,
   input wire line_commit_o,
   input wire inval_req_o,
   input wire [AW-1:0] inval_addr_o,
   input wire flush_req_o
);
   // cycles since the cache enable pin was last low
   reg [3:0] ken_age_r;
   always @(posedge clk_i) begin
      if (rst_i || !cacheable_enable_n_i) ken_age_r <= 4'h0;
      else if (ken_age_r != 4'hF) ken_age_r <= ken_age_r + 4'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_bus_backoff_n_float: assert property (!bus_backoff_n_i [*4] |-> !addr_oe_o && !ctrl_oe_o)
      else $error("bus driven under backoff");
   a_no_hold_ack: assert property (!$past(bus_hold_active_i) |-> !hold_ack_o)
      else $error("hold ack without hold");
   a_bus_backoff_n_no_ack: assert property (!bus_backoff_n_i [*4] |-> !cyc_ack_o)
      else $error("cycle acked under backoff");
   a_address_hold_req_addr: assert property (address_hold_req_i [*4] |-> !addr_oe_o)
      else $error("address driven under address hold");
   a_inval_src: assert property (inval_req_o |-> !$past(external_address_strobe_n_i, 3) &&
      inval_addr_o == $past(addr_i, 3))
      else $error("invalidation without strobe");
   a_fill_ken: assert property ($rose(line_fill_o) |-> ken_age_r < 4'h6)
      else $error("fill without cache enable");
   a_commit_ken: assert property (line_commit_o |->
      (line_fill_o || $past(line_fill_o)) && ken_age_r < 4'h8)
      else $error("commit without cache enable");
   a_flush_src: assert property (flush_req_o |-> !$past(flush_n_i, 3) ##1 !flush_req_o)
      else $error("flush without flush pin");
   a_attr_timing: assert property (page_attr_oe_o == ctrl_oe_o)
      else $error("attribute enable apart from cycle pins");
   a_hold_attr: assert property (hold_ack_o |-> !page_attr_oe_o)
      else $error("attributes driven in hold");
   c_bus_backoff_n: cover property (!bus_backoff_n_i [*4] ##1 bus_backoff_n_i);
   c_inval: cover property (inval_req_o);
   c_commit: cover property (line_commit_o);
endmodule
bind bbc_ctrl bbc_ctrl_props #(.AW(AW)) u_props (.clk_i, .rst_i, .bus_backoff_n_i,
   .address_hold_req_i, .external_address_strobe_n_i, .cacheable_enable_n_i, .flush_n_i,
   .bus_hold_active_i, .addr_i, .addr_oe_o, .ctrl_oe_o, .hold_ack_o, .page_attr_oe_o,
   .cyc_ack_o, .line_fill_o, .line_commit_o, .inval_req_o, .inval_addr_o, .flush_req_o);

// ---- verification/bbc_sys_model.sv ----
// system side model: answers bus cycles with ready, burst ready and cache enable
`timescale 1ns/1ns
module bbc_sys_model (
   input wire clk_i,
   input wire rst_i,
   input wire addr_strobe_n_i,
   input wire [1:0] ken_mode_i,
   input wire burst_i,
   input wire [3:0] dly_i,
   output reg ready_n_o,
   output reg burst_ready_n_o,
   output reg ken_n_o
);
   reg busy_r;
   reg [4:0] cnt_r;
   wire [4:0] d5 = {1'b0, dly_i};
   wire [4:0] last = d5 + (burst_i ? 5'h04 : 5'h01);
   always @(posedge clk_i) begin
      ready_n_o <= 1'b1;
      burst_ready_n_o <= 1'b1;
      ken_n_o <= 1'b1;
      if (rst_i) begin
         busy_r <= 1'b0;
         cnt_r <= 5'h00;
      end else if (!addr_strobe_n_i) begin
         busy_r <= 1'b1;
         cnt_r <= 5'h00;
      end else if (busy_r) begin
         cnt_r <= cnt_r + 5'h01;
         // mode 1 keeps enable low up to the last beat, mode 2 only before the first
         if (cnt_r >= d5 && cnt_r < last && (ken_mode_i == 2'h1 || cnt_r == d5))
            ken_n_o <= ken_mode_i == 2'h0;
         if (cnt_r > d5 && cnt_r <= last) begin
            ready_n_o <= burst_i;
            burst_ready_n_o <= !burst_i;
         end
         if (cnt_r == last) busy_r <= 1'b0;
      end
   end
endmodule

// ---- verification/tb_bus_backoff_cache_ctrl_pins.sv ----
// testbench for the backoff, address hold and cache control pin block
`timescale 1ns/1ns
module tb_bus_backoff_cache_ctrl_pins;
   localparam AW = 30;
   reg clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   reg bus_backoff_n_i = 1'h1, address_hold_req_i = 1'h0, external_address_strobe_n_i = 1'h1;
   reg flush_n_i = 1'h1, bus_hold_active_i = 1'h0, cyc_req_i = 1'h0, burst = 1'h0;
   reg cyc_write_i = 1'h0, cyc_cacheable_i = 1'h0;
   reg [7:0] wb_adr_i = 8'h00;
   reg [3:0] wb_sel_i = 4'hF, dly = 4'h1;
   reg [31:0] wb_dat_i = 32'h0, q;
   reg [AW-1:0] addr_i = 30'h0, cyc_addr_i = 30'h100, ia;
   reg [1:0] cyc_attr_src_i = 2'h0, pte_attr_i = 2'h1, pde_attr_i = 2'h2, ken_mode = 2'h0;
   reg [2:0] at_s;
   reg fill_q;
   wire [31:0] wb_dat_o;
   wire [AW-1:0] addr_o, inval_addr_o;
   wire wb_ack_o, cacheable_enable_n_i, ready_n_i, burst_ready_n_i, addr_oe_o, addr_strobe_n_o;
   wire write_read_o, ctrl_oe_o, data_oe_o, hold_ack_o, page_write_through_o;
   wire page_cache_disable_o, page_attr_oe_o, cyc_ack_o, line_fill_o, line_commit_o;
   wire inval_req_o, flush_req_o;
   integer fails = 0, checks_done = 0, nstb, nack, nfill, ncom, ninv, nfl;
   bbc_ctrl #(.AW(AW)) uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_backoff_n_i, .address_hold_req_i,
      .external_address_strobe_n_i, .cacheable_enable_n_i, .flush_n_i, .ready_n_i,
      .burst_ready_n_i, .addr_i, .addr_o, .addr_oe_o, .addr_strobe_n_o, .write_read_o,
      .ctrl_oe_o, .data_oe_o, .hold_ack_o, .page_write_through_o, .page_cache_disable_o,
      .page_attr_oe_o, .bus_hold_active_i, .cyc_req_i, .cyc_addr_i, .cyc_write_i,
      .cyc_cacheable_i, .cyc_attr_src_i, .pte_attr_i, .pde_attr_i, .cyc_ack_o, .line_fill_o,
      .line_commit_o, .inval_req_o, .inval_addr_o, .flush_req_o);
   bbc_sys_model u_sys (.clk_i, .rst_i, .addr_strobe_n_i(addr_strobe_n_o), .ken_mode_i(ken_mode),
      .burst_i(burst), .dly_i(dly), .ready_n_o(ready_n_i), .burst_ready_n_o(burst_ready_n_i),
      .ken_n_o(cacheable_enable_n_i));
   initial forever #5 clk_i = ~clk_i;
   // outputs are sampled mid-cycle, where they are settled
   always @(negedge clk_i) begin
      fill_q <= line_fill_o;
      if (addr_strobe_n_o === 1'b0) begin
         nstb++;
         at_s = {write_read_o, page_cache_disable_o, page_write_through_o};
      end
      if (cyc_ack_o === 1'b1) nack++;
      if (line_fill_o === 1'b1 && fill_q !== 1'b1) nfill++;
      if (line_commit_o === 1'b1) ncom++;
      if (inval_req_o === 1'b1) begin
         ninv++;
         ia = inval_addr_o;
      end
      if (flush_req_o === 1'b1) nfl++;
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task clr;
      @(posedge clk_i);
      {nstb, nack, nfill, ncom, ninv, nfl} = 0;
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      n = 0;
      @(negedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      q = wb_dat_o;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (n == 50) chk("wb_ack", 1, 0);
   endtask
   task cyc(input [1:0] s, input w, input c);
      integer n;
      @(posedge clk_i);
      {cyc_attr_src_i, cyc_write_i, cyc_cacheable_i, cyc_req_i} <= {s, w, c, 1'b1};
      n = 0;
      @(negedge clk_i);
      while (cyc_ack_o !== 1'b1 && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
      cyc_req_i <= 1'b0;
      if (n == 300) chk("cyc_ack", 1, 0);
   endtask
   task wstb;
      integer n;
      n = 0;
      @(negedge clk_i);
      while (addr_strobe_n_o !== 1'b0 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
   endtask
   task t_regs;
      wb(0, 8'h00, 0);
      chk("ctrl_rst", 0, q);
      wb(0, 8'h04, 0);
      chk("base_rst", 0, q);
      wb(1, 8'h10, 32'hFFFFFFFF);
      wb(0, 8'h10, 0);
      chk("unmapped", 0, q);
      wb(1, 8'h04, 32'hFFFFFFFF);
      wb(0, 8'h04, 0);
      chk("base", 32'h18, q);
      $display("test regs done");
   endtask
   task t_attr;
      integer i;
      reg [1:0] a;
      for (i = 0; i < 12; i++) begin
         a = (i < 4) ? pte_attr_i : (i < 8) ? pde_attr_i : 2'h3;
         wb(1, 8'h00, i & 3);
         cyc(i[3:2], i > 5, 0);
         chk("pwt", i[0] & a[0], at_s[0]);
         if (i[0] || !i[1]) chk("pcd", (i[0] & a[1]) | i[1], at_s[1]);
         chk("wr", i > 5, at_s[2]);
      end
      $display("test attributes done");
   endtask
   task t_fill;
      integer m;
      wb(1, 8'h00, 0);
      for (m = 0; m < 3; m++) begin
         clr;
         ken_mode <= m[1:0];
         burst <= m != 0;
         cyc(0, 0, 1);
         repeat (4) @(posedge clk_i);
         chk("fill", m != 0, nfill);
         chk("commit", m == 1, ncom);
      end
      $display("test fill done");
   endtask
   task t_bus_backoff_n;
      clr;
      {ken_mode, burst, dly} <= 7'h0;
      fork
         cyc(0, 0, 0);
         begin
            wstb;
            bus_backoff_n_i <= 1'b0;
            repeat (8) @(posedge clk_i);
            chk("addr_oe", 0, addr_oe_o);
            chk("ctrl_oe", 0, ctrl_oe_o);
            chk("hold_ack", 0, hold_ack_o);
            chk("ack", 0, nack);
            bus_backoff_n_i <= 1'b1;
         end
      join
      chk("strobes", 2, nstb);
      chk("acks", 1, nack);
      $display("test backoff done");
   endtask
   task t_address_hold_req;
      clr;
      dly <= 4'hF;
      fork
         cyc(0, 1, 0);
         begin
            wstb;
            address_hold_req_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            chk("addr_oe", 0, addr_oe_o);
            chk("ctrl_oe", 1, ctrl_oe_o);
            chk("data_oe", 1, data_oe_o);
            addr_i <= 30'h2AAAAAA5;
            external_address_strobe_n_i <= 1'b0;
            @(posedge clk_i);
            addr_i <= 30'h1555555A;
            external_address_strobe_n_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            address_hold_req_i <= 1'b0;
         end
      join
      chk("inval", 1, ninv);
      chk("inval_addr", 30'h2AAAAAA5, ia);
      $display("test address hold done");
   endtask
   task t_misc;
      clr;
      flush_n_i <= 1'b0;
      @(posedge clk_i);
      flush_n_i <= 1'b1;
      bus_hold_active_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("flush", 1, nfl);
      chk("hold_ack", 1, hold_ack_o);
      chk("attr_oe", 0, page_attr_oe_o);
      bus_hold_active_i <= 1'b0;
      $display("test flush and hold done");
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_attr;
      t_fill;
      t_bus_backoff_n;
      t_address_hold_req;
      t_misc;
      print_verdict;
   end
   initial begin
      #100000;
      fails++;
      print_verdict;
   end
endmodule
